/* File: iasq_sequencer.v */
// Start and stop arm trees of the interval counter, with an Avalon-MM register port.
// Assumes asynchronous pins for arm and event inputs; meas_done comes from clk_sys logic.
//
// Overview of operation
// - Outer start layer: at once or external, reset at once
// - Start arm edge rising or falling, used when external
// - Start delay mode none, time or events, reset none
// - Start event count 1 to 99,999,999, reset 1
// - Start time 100 ns to 0.9999999 s, reset 100 ns
// - Outer stop layer: at once or external, reset at once
// - Stop arm edge rising or falling, used when external
// - Stop delay mode none, time or events, reset none
// - Stop event count 1 to 99,999,999, reset 1
// - Stop time 100 ns to 10 s, reset 100 ns
// - Inner delays ignored for pulse-type functions
// - Pulse-type functions armed by outer start only
// - Interval: start delay needs external start arm
`timescale 1ns/1ps
`default_nettype none
`include "iasq_map.vh"

module iasq_sequencer (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Pins
  input  wire        ext_start_arm,
  input  wire        ext_stop_arm,
  input  wire        start_event_in,
  input  wire        stop_event_in,
  // Measurement core
  input  wire        meas_done,
  output wire        start_armed,
  output wire        stop_armed
);

  localparam [3:0] S_IDLE  = 4'h1;
  localparam [3:0] S_OUTER = 4'h2;
  localparam [3:0] S_DELAY = 4'h4;
  localparam [3:0] S_ARMED = 4'h8;

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          be_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  function [`IASQ_VAL_W-1:0] clamp;
    input [31:0]             v;
    input [`IASQ_VAL_W-1:0]  hi;
    begin
      if (v < {5'h00, `IASQ_COUNT_MIN}) begin
        clamp = `IASQ_COUNT_MIN;
      end else if (v > {5'h00, hi}) begin
        clamp = hi;
      end else begin
        clamp = v[`IASQ_VAL_W-1:0];
      end
    end
  endfunction

  function arm_edge;
    input rise;
    input fall;
    input neg;
    begin
      arm_edge = neg ? fall : rise;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------------------
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [3:0] sync3_q;
  reg [3:0] level_q;
  reg [3:0] level_d;
  reg [3:0] prev_q;
  integer   k;

  always @* begin
    level_d = level_q;
    for (k = 0; k < 4; k = k + 1) begin
      if (sync2_q[k] == sync3_q[k]) begin
        level_d[k] = sync3_q[k];
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
      level_q <= 4'h0;
      prev_q  <= 4'h0;
    end else begin
      sync1_q <= {stop_event_in, start_event_in, ext_stop_arm, ext_start_arm};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
      prev_q  <= level_q;
    end
  end

  wire [3:0] rise = level_q & ~prev_q;
  wire [3:0] fall = ~level_q & prev_q;

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  reg [`IASQ_CTRL_W-1:0] ctrl_q;
  reg [`IASQ_VAL_W-1:0]  start_time_q;
  reg [`IASQ_VAL_W-1:0]  start_count_q;
  reg [`IASQ_VAL_W-1:0]  stop_time_q;
  reg [`IASQ_VAL_W-1:0]  stop_count_q;
  reg                    ack_q;
  reg [31:0]             rdata_q;
  reg [31:0]             rdata_d;
  reg                    go_q;
  reg                    abort_q;
  reg [3:0]              st_q;
  reg [3:0]              sp_q;

  wire req   = avs_read | avs_write;
  wire wr_en = avs_write & ack_q;
  wire [31:0] wmerge_ctrl = be_merge({23'h000000, ctrl_q}, avs_writedata, avs_byteenable);

  wire pulse_func = ctrl_q[`IASQ_CTRL_FUNC];
  wire start_ext  = ctrl_q[`IASQ_CTRL_START_EXT];
  wire stop_ext   = ctrl_q[`IASQ_CTRL_STOP_EXT];
  wire [1:0] start_mode_raw = ctrl_q[`IASQ_CTRL_START_MODE];
  wire [1:0] stop_mode_raw  = ctrl_q[`IASQ_CTRL_STOP_MODE];

  // Disallowed interval combinations flag an error and fall back to the legal subset
  wire cfg_err = ~pulse_func & ~start_ext &
                 ((start_mode_raw != `IASQ_MODE_NONE) | stop_ext);
  wire [1:0] start_mode = (pulse_func | ~start_ext) ? `IASQ_MODE_NONE
                                                   : start_mode_raw;
  wire [1:0] stop_mode  = pulse_func ? `IASQ_MODE_NONE : stop_mode_raw;
  wire stop_ext_eff     = stop_ext & start_ext & ~pulse_func;

  wire busy = ~st_q[0] | ~sp_q[0];

  always @* begin
    case (avs_address)
      `IASQ_OFS_CTRL:        rdata_d = {23'h000000, ctrl_q};
      `IASQ_OFS_START_TIME:  rdata_d = {5'h00, start_time_q};
      `IASQ_OFS_START_COUNT: rdata_d = {5'h00, start_count_q};
      `IASQ_OFS_STOP_TIME:   rdata_d = {5'h00, stop_time_q};
      `IASQ_OFS_STOP_COUNT:  rdata_d = {5'h00, stop_count_q};
      `IASQ_OFS_STATUS:      rdata_d = {28'h0000000, cfg_err, busy, sp_q[3], st_q[3]};
      default:               rdata_d = 32'h00000000;
    endcase
  end

  // One wait cycle per access; the request completes on the second edge
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_q         <= 1'b0;
      rdata_q       <= 32'h00000000;
      ctrl_q        <= `IASQ_CTRL_RST;
      start_time_q  <= `IASQ_TIME_RST;
      start_count_q <= `IASQ_COUNT_RST;
      stop_time_q   <= `IASQ_TIME_RST;
      stop_count_q  <= `IASQ_COUNT_RST;
      go_q          <= 1'b0;
      abort_q       <= 1'b0;
    end else begin
      ack_q   <= req & ~ack_q;
      go_q    <= 1'b0;
      abort_q <= 1'b0;
      if (avs_read & ~ack_q) begin
        rdata_q <= rdata_d;
      end
      if (wr_en) begin
        case (avs_address)
          `IASQ_OFS_CTRL:
            ctrl_q <= wmerge_ctrl[`IASQ_CTRL_W-1:0];
          `IASQ_OFS_START_TIME:
            start_time_q <= clamp(be_merge({5'h00, start_time_q}, avs_writedata,
                                  avs_byteenable), `IASQ_START_TIME_MAX);
          `IASQ_OFS_START_COUNT:
            start_count_q <= clamp(be_merge({5'h00, start_count_q}, avs_writedata,
                                   avs_byteenable), `IASQ_COUNT_MAX);
          `IASQ_OFS_STOP_TIME:
            stop_time_q <= clamp(be_merge({5'h00, stop_time_q}, avs_writedata,
                                 avs_byteenable), `IASQ_STOP_TIME_MAX);
          `IASQ_OFS_STOP_COUNT:
            stop_count_q <= clamp(be_merge({5'h00, stop_count_q}, avs_writedata,
                                  avs_byteenable), `IASQ_COUNT_MAX);
          `IASQ_OFS_CMD: begin
            go_q    <= avs_byteenable[0] & avs_writedata[`IASQ_CMD_GO];
            abort_q <= avs_byteenable[0] & avs_writedata[`IASQ_CMD_ABORT];
          end
          default: ;
        endcase
      end
    end
  end

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  // ----------------------------------------------------------------------------
  // Start arm tree
  // ----------------------------------------------------------------------------
  wire cancel      = abort_q | meas_done;
  wire start_edge  = arm_edge(rise[0], fall[0], ctrl_q[`IASQ_CTRL_START_NEG]);
  wire start_outer = ~start_ext | start_edge;
  wire start_dly_go;
  wire start_dly_done;

  assign start_dly_go = ((st_q == S_IDLE) & go_q & ~start_ext) |
                        ((st_q == S_OUTER) & start_outer);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
    end else if (cancel) begin
      st_q <= S_IDLE;
    end else begin
      case (st_q)
        S_IDLE:  if (go_q) begin
          st_q <= start_ext ? S_OUTER : S_DELAY;
        end
        S_OUTER: if (start_outer) begin
          st_q <= S_DELAY;
        end
        S_DELAY: if (start_dly_done) begin
          st_q <= S_ARMED;
        end
        S_ARMED: st_q <= S_ARMED;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  iasq_delay u_start_delay (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .begin_pulse (start_dly_go),
    .cancel      (cancel),
    .mode        (start_mode),
    .time_ticks  (start_time_q),
    .event_total (start_count_q),
    .event_pulse (rise[2]),
    .done_pulse  (start_dly_done)
  );

  // ----------------------------------------------------------------------------
  // Stop arm tree, started once the start edge is armed
  // ----------------------------------------------------------------------------
  wire stop_edge  = arm_edge(rise[1], fall[1], ctrl_q[`IASQ_CTRL_STOP_NEG]);
  wire stop_outer = ~stop_ext_eff | stop_edge;
  wire stop_trig  = (sp_q == S_IDLE) & (st_q == S_DELAY) & start_dly_done;
  wire stop_dly_go;
  wire stop_dly_done;

  assign stop_dly_go = (stop_trig & ~stop_ext_eff) |
                       ((sp_q == S_OUTER) & stop_outer);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sp_q <= S_IDLE;
    end else if (cancel) begin
      sp_q <= S_IDLE;
    end else begin
      case (sp_q)
        S_IDLE:  if (stop_trig) begin
          sp_q <= stop_ext_eff ? S_OUTER : S_DELAY;
        end
        S_OUTER: if (stop_outer) begin
          sp_q <= S_DELAY;
        end
        S_DELAY: if (stop_dly_done) begin
          sp_q <= S_ARMED;
        end
        S_ARMED: sp_q <= S_ARMED;
        default: sp_q <= S_IDLE;
      endcase
    end
  end

  iasq_delay u_stop_delay (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .begin_pulse (stop_dly_go),
    .cancel      (cancel),
    .mode        (stop_mode),
    .time_ticks  (stop_time_q),
    .event_total (stop_count_q),
    .event_pulse (rise[3]),
    .done_pulse  (stop_dly_done)
  );

  assign start_armed = st_q[3];
  assign stop_armed  = sp_q[3];

endmodule
`default_nettype wire

/* File: iasq_map.vh */
// Register offsets, field positions, reset values and timing counts of the arm sequencer.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef IASQ_MAP_VH
`define IASQ_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define IASQ_OFS_CTRL        5'h00
`define IASQ_OFS_START_TIME  5'h04
`define IASQ_OFS_START_COUNT 5'h08
`define IASQ_OFS_STOP_TIME   5'h0c
`define IASQ_OFS_STOP_COUNT  5'h10
`define IASQ_OFS_CMD         5'h14
`define IASQ_OFS_STATUS      5'h18

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define IASQ_CTRL_FUNC       0
`define IASQ_CTRL_START_EXT  1
`define IASQ_CTRL_START_NEG  2
`define IASQ_CTRL_START_MODE 4:3
`define IASQ_CTRL_STOP_EXT   5
`define IASQ_CTRL_STOP_NEG   6
`define IASQ_CTRL_STOP_MODE  8:7
`define IASQ_CTRL_W          9
`define IASQ_CTRL_RST        9'h000

// Command and status bits
`define IASQ_CMD_GO          0
`define IASQ_CMD_ABORT       1
`define IASQ_STS_START_ARMED 0
`define IASQ_STS_STOP_ARMED  1
`define IASQ_STS_BUSY        2
`define IASQ_STS_CFG_ERR     3

// ----------------------------------------------------------------------------
// Inner delay modes
// ----------------------------------------------------------------------------
`define IASQ_MODE_NONE       2'h0
`define IASQ_MODE_TIME       2'h1
`define IASQ_MODE_EVENT      2'h2

// ----------------------------------------------------------------------------
// Value widths, limits and reset values
// ----------------------------------------------------------------------------
`define IASQ_VAL_W           27
`define IASQ_COUNT_MIN       27'h0000001
`define IASQ_COUNT_MAX       27'h5f5e0ff
`define IASQ_COUNT_RST       27'h0000001
`define IASQ_START_TIME_MAX  27'h098967f
`define IASQ_STOP_TIME_MAX   27'h5f5e100
`define IASQ_TIME_MIN        27'h0000001
`define IASQ_TIME_RST        27'h0000001

// ----------------------------------------------------------------------------
// Timing: one time step of 100 ns counted in 50 ns clock periods
// ----------------------------------------------------------------------------
`define IASQ_TICK_NS         100
`define IASQ_CLK_NS          50
`define IASQ_CYC_PER_TICK    ((`IASQ_TICK_NS + `IASQ_CLK_NS - 1) / `IASQ_CLK_NS)
`define IASQ_PRE_W           2

`endif

/* File: iasq_delay.v */
// Inner delay layer of one arm tree: none, a time in 100 ns steps, or a count of events.
// Assumes event_pulse is a single-cycle pulse already synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "iasq_map.vh"

module iasq_delay (
  // Clock and reset
  input  wire                   clk_sys,
  input  wire                   rst,
  // Control
  input  wire                   begin_pulse,
  input  wire                   cancel,
  input  wire [1:0]             mode,
  input  wire [`IASQ_VAL_W-1:0] time_ticks,
  input  wire [`IASQ_VAL_W-1:0] event_total,
  input  wire                   event_pulse,
  // Result
  output wire                   done_pulse
);

  localparam integer           PRE_LAST_I = `IASQ_CYC_PER_TICK - 1;
  localparam [`IASQ_PRE_W-1:0] PRE_LAST   = PRE_LAST_I[`IASQ_PRE_W-1:0];

  reg                   run_q;
  reg [`IASQ_VAL_W-1:0] left_q;
  reg [`IASQ_PRE_W-1:0] pre_q;
  reg                   done_q;
  reg                   is_time_q;

  wire tick = is_time_q ? (pre_q == PRE_LAST) : event_pulse;

  // ----------------------------------------------------------------------------
  // Down counter of ticks or events
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_q     <= 1'b0;
      left_q    <= {`IASQ_VAL_W{1'b0}};
      pre_q     <= {`IASQ_PRE_W{1'b0}};
      done_q    <= 1'b0;
      is_time_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (cancel) begin
        run_q <= 1'b0;
      end else if (begin_pulse) begin
        pre_q <= {`IASQ_PRE_W{1'b0}};
        if (mode == `IASQ_MODE_TIME) begin
          run_q     <= 1'b1;
          is_time_q <= 1'b1;
          left_q    <= time_ticks;
        end else if (mode == `IASQ_MODE_EVENT) begin
          run_q     <= 1'b1;
          is_time_q <= 1'b0;
          left_q    <= event_total;
        end else begin
          done_q <= 1'b1;
        end
      end else if (run_q) begin
        pre_q <= (pre_q == PRE_LAST) ? {`IASQ_PRE_W{1'b0}} : pre_q + 1'b1;
        if (tick) begin
          left_q <= left_q - 1'b1;
          if (left_q == `IASQ_COUNT_MIN) begin
            run_q  <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end

  assign done_pulse = done_q;

endmodule
`default_nettype wire

/* File: iasq_pins.sv */
// Partner model: external arm pins and event pins of the counter.
// Assumes the bench calls its tasks; pins change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module iasq_pins (
  // Clock
  input  wire  clk_sys,
  // Arm and event pins
  output logic ext_start_arm,
  output logic ext_stop_arm,
  output logic start_event_in,
  output logic stop_event_in
);
  initial begin
    ext_start_arm  = 1'b0;
    ext_stop_arm   = 1'b0;
    start_event_in = 1'b0;
    stop_event_in  = 1'b0;
  end

  // Sets one arm pin level, then holds it for a number of cycles
  task automatic arm(input logic stp, input logic lvl, input int hold);
    @(posedge clk_sys);
    if (stp) ext_stop_arm <= lvl;
    else ext_start_arm <= lvl;
    repeat (hold) @(posedge clk_sys);
  endtask

  // Wide pulses so the pin filter sees every one of them
  task automatic events(input logic stp, input int cnt);
    repeat (cnt) begin
      @(posedge clk_sys);
      if (stp) stop_event_in <= 1'b1;
      else start_event_in <= 1'b1;
      repeat (6) @(posedge clk_sys);
      if (stp) stop_event_in <= 1'b0;
      else start_event_in <= 1'b0;
      repeat (10) @(posedge clk_sys);
    end
  endtask
endmodule

`default_nettype wire

/* File: iasq_sequencer_chk.sv */
// Checker for bus handshake and armed-state relations of the arm sequencer.
// Assumes it is bound to iasq_sequencer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module iasq_chk (
  // Clock and reset
  input wire        clk_sys,
  input wire        rst,
  // Avalon-MM
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Measurement core
  input wire        meas_done,
  input wire        start_armed,
  input wire        stop_armed
);
  logic [2:0] hist_q;
  logic       quiet;

  // No write or end of measurement in this cycle or the last three
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) hist_q <= 3'h7;
    else hist_q <= {hist_q[1:0], avs_write | meas_done};
  end
  assign quiet = ~(avs_write | meas_done) & (hist_q == 3'h0);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");
  AST_WR_WAIT: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write not answered after one wait cycle");
  AST_IDLE_NOWAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait request without a request");
  AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  AST_STOP_NEEDS_START: assert property (stop_armed |-> start_armed)
    else $error("stop armed before start");
  AST_DONE_CLEARS: assert property (meas_done |-> ##[1:2] (!start_armed && !stop_armed))
    else $error("armed state kept after measurement end");
  AST_START_HOLD: assert property (start_armed && quiet |=> start_armed)
    else $error("start armed dropped on its own");
  AST_STOP_HOLD: assert property (stop_armed && quiet |=> stop_armed)
    else $error("stop armed dropped on its own");
endmodule

bind iasq_sequencer iasq_chk u_chk (
  .clk_sys        (clk_sys),
  .rst            (rst),
  .avs_read       (avs_read),
  .avs_write      (avs_write),
  .avs_readdata   (avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .meas_done      (meas_done),
  .start_armed    (start_armed),
  .stop_armed     (stop_armed)
);

`default_nettype wire

/* File: iasq_sequencer_tb_top.sv */
// Self-checking bench of the arm sequencer with a pin partner model.
// Assumes a 50 ns clock and the register map of the design header.
`timescale 1ns/1ps
`default_nettype none
`include "iasq_map.vh"

module iasq_sequencer_tb_top;
  logic        clk_sys;
  logic        rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         ext_start_arm;
  wire         ext_stop_arm;
  wire         start_event_in;
  wire         stop_event_in;
  logic        meas_done;
  wire         start_armed;
  wire         stop_armed;
  int          miscompares;
  int          samples_checked;
  int          n;
  logic [31:0] rd;

  iasq_sequencer dut (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_start_arm(ext_start_arm), .ext_stop_arm(ext_stop_arm),
    .start_event_in(start_event_in), .stop_event_in(stop_event_in),
    .meas_done(meas_done), .start_armed(start_armed), .stop_armed(stop_armed));

  iasq_pins pins (
    .clk_sys(clk_sys), .ext_start_arm(ext_start_arm), .ext_stop_arm(ext_stop_arm),
    .start_event_in(start_event_in), .stop_event_in(stop_event_in));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic results;
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tmo;
    miscompares++;
    results();
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int i;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= is_wr;
    avs_read       <= ~is_wr;
    i = 0;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && i < 20) begin
      i++;
      @(posedge clk_sys);
    end
    if (i == 20) tmo();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic wait_arm(input logic stp, input int lim);
    n = 0;
    @(negedge clk_sys);
    while ((stp ? stop_armed : start_armed) !== 1'b1 && n < lim) begin
      n++;
      @(negedge clk_sys);
    end
    if (n == lim) tmo();
  endtask

  task automatic abort_chk;
    wr(`IASQ_OFS_CMD, 32'h2);
    repeat (4) @(negedge clk_sys);
    chk("armed after abort", {start_armed, stop_armed}, 32'h0);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    logic [4:0]  a [9] = '{`IASQ_OFS_START_COUNT, `IASQ_OFS_START_COUNT, `IASQ_OFS_START_TIME,
      `IASQ_OFS_STOP_TIME, `IASQ_OFS_STOP_COUNT, `IASQ_OFS_STOP_COUNT, `IASQ_OFS_STATUS, 5'h1c,
      `IASQ_OFS_CTRL};
    logic [31:0] d [9] = '{32'h0, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h0, 32'h12,
      32'hf, 32'hffffffff, 32'h1ff};
    logic [3:0]  b [9] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h1, 4'hf, 4'hf, 4'hf};
    logic [31:0] e [9] = '{32'h1, 32'h05f5e0ff, 32'h0098967f, 32'h05f5e100, 32'h1, 32'h12,
      32'h0, 32'h0, 32'h1ff};
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, `IASQ_OFS_CTRL + 5'(4 * k), 32'h0, 4'hf);
      chk("reset value", rd, (k == 0 || k == 5) ? 32'h0 : 32'h1);
    end
    for (int k = 0; k < 9; k++) begin
      bus(1'b1, a[k], d[k], b[k]);
      bus(1'b0, a[k], 32'h0, 4'hf);
      chk("register value", rd, e[k]);
    end
  endtask

  task automatic t_arm_at_once;
    wr(`IASQ_OFS_CTRL, 32'h0);
    wr(`IASQ_OFS_CMD, 32'h1);
    wait_arm(1'b0, 10);
    chk("start arm delay", n, 2);
    chk("stop early", stop_armed, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk("stop armed", stop_armed, 1'b1);
    @(posedge clk_sys);
    meas_done <= 1'b1;
    @(posedge clk_sys);
    meas_done <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("armed after done", {start_armed, stop_armed}, 32'h0);
  endtask

  task automatic t_ext;
    for (int g = 0; g < 2; g++) begin
      wr(`IASQ_OFS_CTRL, (g == 1) ? 32'h66 : 32'h22);
      wr(`IASQ_OFS_CMD, 32'h1);
      pins.arm(1'b0, 1'b1, 12);
      chk("start on rise", start_armed, g == 0);
      pins.arm(1'b0, 1'b0, 12);
      chk("start on fall", start_armed, 1'b1);
      chk("stop waits pin", stop_armed, 1'b0);
      pins.arm(1'b1, 1'b1, 12);
      chk("stop on rise", stop_armed, g == 0);
      pins.arm(1'b1, 1'b0, 12);
      chk("stop on fall", stop_armed, 1'b1);
      abort_chk();
    end
  endtask

  task automatic t_time;
    wr(`IASQ_OFS_CTRL, 32'h8a);
    wr(`IASQ_OFS_START_TIME, 32'h5);
    wr(`IASQ_OFS_STOP_TIME, 32'h3);
    wr(`IASQ_OFS_CMD, 32'h1);
    repeat (20) @(negedge clk_sys);
    chk("start before pin", start_armed, 1'b0);
    pins.arm(1'b0, 1'b1, 0);
    wait_arm(1'b0, 60);
    chk("start time delay", n >= 10 && n <= 20, 1'b1);
    wait_arm(1'b1, 40);
    chk("stop time delay", n >= 5 && n <= 10, 1'b1);
    pins.arm(1'b0, 1'b0, 0);
    abort_chk();
  endtask

  task automatic t_event;
    wr(`IASQ_OFS_CTRL, 32'h112);
    wr(`IASQ_OFS_START_COUNT, 32'h3);
    wr(`IASQ_OFS_STOP_COUNT, 32'h2);
    wr(`IASQ_OFS_CMD, 32'h1);
    pins.arm(1'b0, 1'b1, 12);
    pins.events(1'b0, 2);
    chk("start after two", start_armed, 1'b0);
    pins.events(1'b0, 1);
    chk("start after three", start_armed, 1'b1);
    pins.events(1'b1, 1);
    chk("stop after one", stop_armed, 1'b0);
    pins.events(1'b1, 1);
    chk("stop after two", stop_armed, 1'b1);
    pins.arm(1'b0, 1'b0, 0);
    abort_chk();
  endtask

  task automatic t_pulse;
    wr(`IASQ_OFS_CTRL, 32'h129);
    wr(`IASQ_OFS_START_TIME, 32'h3e8);
    wr(`IASQ_OFS_CMD, 32'h1);
    wait_arm(1'b0, 10);
    chk("pulse start delay", n, 2);
    wait_arm(1'b1, 10);
    chk("pulse armed", start_armed, 1'b1);
    abort_chk();
  endtask

  task automatic t_illegal;
    wr(`IASQ_OFS_CTRL, 32'h30);
    wr(`IASQ_OFS_CMD, 32'h1);
    wait_arm(1'b0, 10);
    chk("fallback start", n, 2);
    wait_arm(1'b1, 10);
    bus(1'b0, `IASQ_OFS_STATUS, 32'h0, 4'hf);
    chk("config error", rd[3], 1'b1);
    abort_chk();
  endtask

  initial begin
    rst            = 1'b1;
    avs_address    = 5'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
    meas_done      = 1'b0;
    miscompares    = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_arm_at_once();
    t_ext();
    t_time();
    t_event();
    t_pulse();
    t_illegal();
    results();
  end
endmodule

`default_nettype wire
